/* File: include/rcs_pkg.sv */
// shared constants, the carrier type and the sequence table of the coffee sequencer
package rcs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int CNT_W = 5;                  // step counter width
    localparam int SEL_W = 3;                  // sequence select width
    localparam int ADDR_W = SEL_W + CNT_W;     // table address width
    localparam int BTN_N = 6;                  // number of push buttons
    localparam int DIV_W = 26;                 // step divider width

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 10;         // 100 mhz system clock
    localparam int STEP_TIME_MS = 500;         // 2 hz step source
    localparam int STEP_CYC = (STEP_TIME_MS * 1000000) / CLK_PERIOD_NS; // clocks per step

    ////////////////////////////////////////////////////////////////////////////
    // counts and reset values
    localparam logic [CNT_W-1:0] CNT_REST = 5'h00;  // rest step, no outputs
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;   // last step of a sequence
    localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;   // incrementer step
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;    // select after reset
    localparam logic [DIV_W-1:0] DIV_RST = 26'h0000000; // divider after reset

    ////////////////////////////////////////////////////////////////////////////
    // sequence codes, one per button
    localparam logic [SEL_W-1:0] SEQ_BLACK = 3'h0;   // coffee black
    localparam logic [SEL_W-1:0] SEQ_CREAM = 3'h1;   // coffee cream
    localparam logic [SEL_W-1:0] SEQ_SUGAR = 3'h2;   // coffee sugar
    localparam logic [SEL_W-1:0] SEQ_BOTH = 3'h3;    // coffee cream and sugar
    localparam logic [SEL_W-1:0] SEQ_CHOC = 3'h4;    // hot chocolate
    localparam logic [SEL_W-1:0] SEQ_SOUP = 3'h5;    // soup

    ////////////////////////////////////////////////////////////////////////////
    // one table word: the actuator lines of one step
    typedef struct packed {
        logic cup;      // cup release
        logic water;    // hot water on
        logic coffee;   // coffee release
        logic sugar;    // sugar release
        logic cream;    // cream release
        logic choc;     // chocolate release
        logic soup;     // soup release
        logic busy;     // sequence in progress
    } rcs_ctl_s;

    localparam rcs_ctl_s CTL_RST = 8'h00;      // word after reset, all off

    // table contents: upper bits pick the sequence, lower bits the step
    function automatic rcs_ctl_s rcs_word(input logic [ADDR_W-1:0] addr);
        rcs_ctl_s w;
        logic [SEL_W-1:0] q;
        logic [CNT_W-1:0] s;
        w = CTL_RST;
        q = addr[ADDR_W-1:CNT_W];
        s = addr[CNT_W-1:0];
        if ((q <= SEQ_SOUP) && (s != CNT_REST)) begin
            w.busy = 1'b1;
            w.cup = (s == 5'h01);
            w.water = (s >= 5'h05) && (s <= 5'h18);
            w.coffee = (s >= 5'h07) && (s <= 5'h0b) && (q <= SEQ_BOTH);
            w.sugar = (s >= 5'h0c) && (s <= 5'h0e) && ((q == SEQ_SUGAR) || (q == SEQ_BOTH));
            w.cream = (s >= 5'h0f) && (s <= 5'h12) && ((q == SEQ_CREAM) || (q == SEQ_BOTH));
            w.choc = (s >= 5'h13) && (s <= 5'h16) && (q == SEQ_CHOC);
            w.soup = (s >= 5'h07) && (s <= 5'h16) && (q == SEQ_SOUP);
        end
        return w;
    endfunction

endpackage

/* File: hdl/rcs_rom.sv */
`timescale 1ns/1ps
`default_nettype none
// sequence table with a registered read port; the register is the output buffer
module rcs_rom (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // read port
    input wire logic en,
    input wire logic [rcs_pkg::ADDR_W-1:0] addr,
    output var rcs_pkg::rcs_ctl_s q
);

    ////////////////////////////////////////////////////////////////////////////
    // output buffer loads the word already decoded for the new state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= rcs_pkg::CTL_RST;
        end else if (en) begin
            q <= rcs_pkg::rcs_word(addr);
        end
    end

endmodule // rcs_rom
`default_nettype wire

/* File: hdl/rcs_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_seq #(
    parameter int STEP_CYC = rcs_pkg::STEP_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // front panel pins
    input wire logic [rcs_pkg::BTN_N-1:0] btn,
    input wire logic coin,
    // actuator lines
    output var rcs_pkg::rcs_ctl_s ctl,
    // status
    output logic coin_held,
    output logic running
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    localparam logic [rcs_pkg::DIV_W-1:0] DIV_LAST = rcs_pkg::DIV_W'(STEP_CYC - 1); // divider wrap value

    logic [rcs_pkg::BTN_N-1:0] btn_s1_r; // button sync, first stage
    logic [rcs_pkg::BTN_N-1:0] btn_s2_r; // button sync, second stage
    logic coin_s1_r;                     // coin sync, first stage
    logic coin_s2_r;                     // coin sync, second stage
    logic coin_s3_r;                     // coin edge history
    logic [rcs_pkg::DIV_W-1:0] div_r;    // step divider
    logic [rcs_pkg::CNT_W-1:0] count_r;  // step counter, width from the package
    logic [rcs_pkg::SEL_W-1:0] sel_r;    // held sequence select
    logic coin_r;                        // coin deposit flag
    logic run_r;                         // sequence running
    logic step_d_r;                      // a step loaded the buffer last edge

    wire step_w;                         // one clock per step period
    wire coin_edge_w;                    // coin inserted
    wire any_w;                          // any button pressed
    wire [rcs_pkg::SEL_W-1:0] code_w;    // encoded button
    wire [rcs_pkg::CNT_W-1:0] inc_w;     // count plus one
    wire [rcs_pkg::ADDR_W-1:0] addr_w;   // table address
    wire adv_w;                          // counter advances
    wire start_w;                        // sequence starts
    wire end_w;                          // sequence ends
    rcs_pkg::rcs_ctl_s buf_w;            // buffered word

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers, two flops before use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            btn_s1_r <= '0;
            btn_s2_r <= '0;
            coin_s1_r <= 1'b0;
            coin_s2_r <= 1'b0;
            coin_s3_r <= 1'b0;
        end else begin
            btn_s1_r <= btn;
            btn_s2_r <= btn_s1_r;
            coin_s1_r <= coin;
            coin_s2_r <= coin_s1_r;
            coin_s3_r <= coin_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // step timing source
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= rcs_pkg::DIV_RST;
        end else if (step_w) begin
            div_r <= rcs_pkg::DIV_RST; // wrap once per step period
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    assign step_w = (div_r == DIV_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // button encoder, lowest-numbered button wins
    assign any_w = |btn_s2_r;
    assign code_w = btn_s2_r[0] ? rcs_pkg::SEQ_BLACK :
                    btn_s2_r[1] ? rcs_pkg::SEQ_CREAM :
                    btn_s2_r[2] ? rcs_pkg::SEQ_SUGAR :
                    btn_s2_r[3] ? rcs_pkg::SEQ_BOTH :
                    btn_s2_r[4] ? rcs_pkg::SEQ_CHOC :
                    rcs_pkg::SEQ_SOUP;

    ////////////////////////////////////////////////////////////////////////////
    // next-state decode
    assign coin_edge_w = coin_s2_r & ~coin_s3_r;
    assign inc_w = count_r + rcs_pkg::CNT_ONE;
    assign addr_w = {sel_r, inc_w};
    assign adv_w = run_r & step_w;
    assign buf_w = ctl;
    assign end_w = run_r & step_d_r & ~buf_w.busy;
    assign start_w = ~run_r & coin_r & any_w;

    ////////////////////////////////////////////////////////////////////////////
    // step counter, advanced by the incrementer only while running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= rcs_pkg::CNT_REST;
        end else if (adv_w) begin
            count_r <= inc_w;
        end else if (!run_r) begin
            count_r <= rcs_pkg::CNT_REST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // select holding register, frozen while running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_r <= rcs_pkg::SEL_RST;
        end else if (start_w) begin
            sel_r <= code_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // coin flag: a new coin wins over the end-of-run clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coin_r <= 1'b0;
        end else if (coin_edge_w) begin
            coin_r <= 1'b1;
        end else if (end_w) begin
            coin_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run flag and step marker
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_r <= 1'b0;
            step_d_r <= 1'b0;
        end else begin
            run_r <= start_w | (run_r & ~end_w);
            step_d_r <= adv_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // table with output buffer, loaded on the same edge as the counter
    rcs_rom u_rom (
        .clk(clk),
        .rst(rst),
        .en(adv_w),
        .addr(addr_w),
        .q(ctl)
    );

    assign coin_held = coin_r;
    assign running = run_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // a step while running; the buffer loads on the next edge
    sequence step_seq;
        run_r && step_w;
    endsequence

    // counter wraps from last step to rest
    count_wrap_a: assert property (step_seq and (count_r == rcs_pkg::CNT_MAX) |=> count_r == rcs_pkg::CNT_REST)
        else $error("counter did not wrap to zero");

    // counter advances by exactly one per step
    count_adv_a: assert property (step_seq |=> count_r == $past(count_r) + rcs_pkg::CNT_ONE)
        else $error("counter did not advance by one");

    // counter stands still between steps
    step_only_a: assert property (!step_w && run_r |=> $stable(count_r))
        else $error("counter moved without a step");

    // buffer holds the word of the new count
    buf_word_a: assert property (step_seq |=> ctl == rcs_pkg::rcs_word({sel_r, count_r}))
        else $error("buffer word does not match new state");

    // actuator outputs never change between steps
    out_stable_a: assert property (!step_w |=> $stable(ctl))
        else $error("outputs changed without a step");

    // select frozen while running
    sel_hold_a: assert property (run_r && $past(run_r) |-> $stable(sel_r))
        else $error("select changed during a sequence");

    // run starts only with coin and button
    start_cond_a: assert property ($rose(run_r) |-> $past(coin_r) && $past(any_w))
        else $error("sequence started without coin and button");

    // run ends with busy low, coin cleared together
    end_clear_a: assert property (end_w && !coin_edge_w |=> !run_r && !coin_r)
        else $error("end of sequence did not clear coin and run");

    // idle counter rests at zero
    idle_zero_a: assert property (!run_r && !$past(run_r) |-> count_r == rcs_pkg::CNT_REST)
        else $error("idle counter not at rest step");

    // select latches the encoded button at the start
    sel_load_a: assert property (start_w |=> sel_r == $past(code_w))
        else $error("select did not latch the encoded button");

endmodule // rcs_seq
`default_nettype wire

/* File: sim/rcs_panel.sv */
`timescale 1ns/1ps
`default_nettype none
// stand-in for the front panel and the dispenser: buttons, coin slot, cup count
module rcs_panel (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // actuator lines from the sequencer
    input wire rcs_pkg::rcs_ctl_s ctl,
    // panel pins
    output logic [rcs_pkg::BTN_N-1:0] btn,
    output logic coin
);
    int cups; // cups dropped so far
    logic cup_q; // cup line one clock ago

    ////////////////////////////////////////
    // pins rest low from time zero
    initial begin
        btn = 6'h00;
        coin = 1'b0;
    end

    // the dispenser drops one cup per rising cup line
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cup_q <= 1'b0;
            cups <= 0;
        end else begin
            cup_q <= ctl.cup;
            cups <= cups + int'(ctl.cup & ~cup_q);
        end
    end

    ////////////////////////////////////////
    // hold button n (1 to 6) alone, 0 lets go; caller sits at a falling edge
    task automatic press(input int n);
        btn = (n > 0) ? (6'h01 << (n - 1)) : 6'h00;
    endtask

    // coin pulse long enough to pass the input synchroniser
    task automatic drop_coin();
        coin = 1'b1;
        repeat (4) @(negedge clk);
        coin = 1'b0;
    endtask
endmodule // rcs_panel
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// top of the bench: sequencer, panel model and the scenarios
module testbench;
    localparam int STEP = 10; // short step period for simulation
    logic clk; // system clock
    logic rst; // async reset
    logic [rcs_pkg::BTN_N-1:0] btn; // buttons from panel
    logic coin; // coin pin from panel
    rcs_pkg::rcs_ctl_s ctl; // actuator word
    logic coin_held; // coin flag
    logic running; // run status
    int failures = 0; // mismatches seen
    int compares = 0; // checks made
    int cycles = 0; // clocks since start

    rcs_seq #(.STEP_CYC(STEP)) dut (.clk(clk), .rst(rst), .btn(btn), .coin(coin),
        .ctl(ctl), .coin_held(coin_held), .running(running));
    rcs_panel panel (.clk(clk), .rst(rst), .ctl(ctl), .btn(btn), .coin(coin));

    ////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    ////////////////////////////////////////
    // expected actuator word for sequence q at step s
    function automatic rcs_pkg::rcs_ctl_s want(input int q, input int s);
        rcs_pkg::rcs_ctl_s w;
        w = 8'h00;
        if (s != 0) begin
            w.busy = 1'b1;
            w.cup = (s == 1);
            w.water = (s >= 5 && s <= 24);
            w.coffee = (s >= 7 && s <= 11 && q <= 3);
            w.sugar = (s >= 12 && s <= 14 && (q == 2 || q == 3));
            w.cream = (s >= 15 && s <= 18 && (q == 1 || q == 3));
            w.choc = (s >= 19 && s <= 22 && q == 4);
            w.soup = (s >= 7 && s <= 22 && q == 5);
        end
        return w;
    endfunction

    // one comparison, counted
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic wrap_up();
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////
    // idle after reset; a button without a coin starts nothing
    task automatic t_idle();
        check(ctl, 8'h00);
        check({coin_held, running}, 8'h00);
        panel.press(1);
        repeat (3 * STEP) @(negedge clk);
        check(running, 8'h00);
        check(ctl, 8'h00);
        panel.press(0);
    endtask

    // full run of sequence q; the button is changed mid-run
    task automatic t_run(input int q);
        int k;
        panel.drop_coin();
        for (k = 0; k < 8 && coin_held !== 1'b1; k++) @(negedge clk);
        check(coin_held, 8'h01);
        repeat (2 * STEP) @(negedge clk);
        check(running, 8'h00);
        panel.press(q + 1);
        for (k = 0; k < 8 && running !== 1'b1; k++) @(negedge clk);
        check(running, 8'h01);
        for (k = 0; k < STEP + 4 && ctl.busy !== 1'b1; k++) @(negedge clk);
        check(ctl, want(q, 1));
        panel.press(((q + 1) % 6) + 1);
        for (int s = 2; s < 32; s++) begin
            repeat (STEP) @(negedge clk);
            check(ctl, want(q, s));
        end
        repeat (STEP) @(negedge clk);
        check(ctl, 8'h00);
        repeat (2) @(negedge clk);
        check({coin_held, running}, 8'h00);
        check(8'(panel.cups), 8'(q + 1));
        repeat (3 * STEP) @(negedge clk);
        check(running, 8'h00);
        panel.press(0);
    endtask

    ////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_idle();
        for (int q = 0; q < 6; q++) begin
            t_run(q);
        end
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
